//--- hw/asp_pkg.sv
// shared constants and types for the two-slot audio serial port
// Function
// - each frame carries exactly left and right slots
// - i2s left msb: second cycle after sync falls
// - i2s right msb: second cycle after sync rises
// - bits launched on falling, sampled on rising
// - controller i2s changes sync on rising edges
// - lj left msb in first cycle after rise
// - lj right msb in first cycle after fall
// - target mode self-detects rate and ratio
// - derived clocks drive modulator, filter, control
// - 3.3v 48k family: ratios 16..512, limits
// - 3.3v 44.1k family: low-rate ratio limits
// - 1.8v 48k family keeps small ratios, 8k limits
// - 1.8v: bit clock above 12.288 reserved
// - strap picks format and role
// - target takes clocks, controller drives them
// - msb first two's complement, strapped length in target role, fixed 32 in controller
package asp_pkg;
  localparam int MCLK_HZ = 10_000_000;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_TX_LEFT  = 8'h08;
  localparam logic [7:0] ADDR_TX_RIGHT = 8'h0C;
  localparam logic [7:0] ADDR_RX_LEFT  = 8'h10;
  localparam logic [7:0] ADDR_RX_RIGHT = 8'h14;
  localparam logic [7:0] ADDR_FRAME    = 8'h18;
  localparam int CTRL_EN_POS = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int ST_LOCK_POS  = 0;
  localparam int ST_ERR_POS   = 1;
  localparam int ST_FAM_POS   = 2;
  localparam int ST_RATE_POS  = 4;
  localparam int ST_RATIO_POS = 8;
  localparam int ST_MODE_POS  = 20;
  localparam logic [5:0] WL_LONG  = 6'h20;
  localparam logic [5:0] WL_SHORT = 6'h18;
  localparam int CTL_RATIO = 64;
  localparam int RATIO_N = 11;
  localparam int RATIO_TAB [RATIO_N] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512};
  localparam int RATE_N = 7;
  localparam int FS48_CYC [RATE_N] = '{1250, 625, 417, 313, 208, 104, 52};
  localparam int FS44_CYC [RATE_N] = '{1361, 680, 454, 340, 227, 113, 57};
  localparam int CYC_TOL = 2;
  localparam longint MAX33_48_100HZ = 245760;
  localparam longint MAX33_44_100HZ = 225792;
  localparam longint MAX18_100HZ = 122880;
  localparam longint MCLK_100HZ = MCLK_HZ / 100;
  localparam int FS_TIMEOUT_US = 200;
  localparam int FS_TIMEOUT_CYC = FS_TIMEOUT_US * (MCLK_HZ / 1_000_000);
  localparam int BCLK_HALF_DEF = 2;
  typedef enum logic [1:0] {
    ASP_TGT_I2S = 2'b00,
    ASP_CTL_I2S = 2'b01,
    ASP_TGT_LJ  = 2'b10,
    ASP_RSVD    = 2'b11
  } asp_mode_e;
  typedef enum logic [1:0] {
    DET_WAIT = 2'b00,
    DET_MEAS = 2'b01,
    DET_LOCK = 2'b10
  } asp_det_e;
endpackage

//--- hw/asp_det_if.sv
// carrier between the port core and the clock detector
`timescale 1ns/1ns
interface asp_det_if;
  logic        bclk_rise;
  logic        fs_rise;
  logic        io33;
  logic        meas_en;
  logic [9:0]  ratio;
  logic [15:0] frame_cyc;
  logic [2:0]  rate_idx;
  logic        fam44;
  logic        valid;
  logic        err;
  modport det (input bclk_rise, fs_rise, io33, meas_en,
               output ratio, frame_cyc, rate_idx, fam44, valid, err);
  modport core (output bclk_rise, fs_rise, io33, meas_en,
                input ratio, frame_cyc, rate_idx, fam44, valid, err);
endinterface

//--- hw/asp_clk_detect.sv
// frame rate and bit-clock ratio detector for target role
`timescale 1ns/1ns
module asp_clk_detect (
  input wire logic mclk,
  input wire logic rst,
  asp_det_if.det   det
);
  logic [15:0]        cyc_q;
  logic [9:0]         bc_q;
  asp_pkg::asp_det_e  st_q;
  logic [2:0]         rate_idx;
  logic               fam44;
  logic               rate_hit;
  logic               ratio_hit;
  logic               low_rsvd;
  logic               too_fast;
  logic               fit;
  logic               tmo;
  longint             lim;

  function automatic logic near_cyc(input logic [15:0] c, input int r);
    int d;
    d = int'(c) - r;
    return (d <= asp_pkg::CYC_TOL) && (d >= -asp_pkg::CYC_TOL);
  endfunction

  always_comb begin
    rate_idx  = 3'h0;
    fam44     = 1'b0;
    rate_hit  = 1'b0;
    ratio_hit = 1'b0;
    for (int i = 0; i < asp_pkg::RATE_N; i++) begin
      if (near_cyc(cyc_q, asp_pkg::FS48_CYC[i])) begin
        rate_idx = 3'(i);
        rate_hit = 1'b1;
      end else if (near_cyc(cyc_q, asp_pkg::FS44_CYC[i])) begin
        rate_idx = 3'(i);
        fam44    = 1'b1;
        rate_hit = 1'b1;
      end
    end
    for (int j = 0; j < asp_pkg::RATIO_N; j++) begin
      if (int'(bc_q) == asp_pkg::RATIO_TAB[j]) begin
        ratio_hit = 1'b1;
      end
    end
  end

  // lowest rates lose their smallest ratios
  assign low_rsvd = ((rate_idx == 3'h0) && !fam44 && (bc_q < 10'h020))
                  || ((rate_idx == 3'h0) && fam44 && (bc_q < 10'h030))
                  || ((rate_idx == 3'h1) && fam44 && (bc_q == 10'h010));
  assign lim = !det.io33 ? asp_pkg::MAX18_100HZ
             : fam44 ? asp_pkg::MAX33_44_100HZ : asp_pkg::MAX33_48_100HZ;
  // compare bclk rate against limit without a divider
  assign too_fast = longint'(bc_q) * asp_pkg::MCLK_100HZ > lim * longint'(cyc_q);
  assign fit = rate_hit && ratio_hit && !low_rsvd && !too_fast;
  assign tmo = (cyc_q == 16'(asp_pkg::FS_TIMEOUT_CYC));

  always_ff @(posedge mclk) begin
    if (rst || !det.meas_en) begin
      cyc_q <= 16'h0000;
    end else if (det.fs_rise) begin
      cyc_q <= 16'h0001;
    end else if (!tmo) begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !det.meas_en) begin
      bc_q <= 10'h000;
    end else if (det.fs_rise) begin
      bc_q <= 10'h001;
    end else if (det.bclk_rise && (bc_q != 10'h3FF)) begin
      bc_q <= bc_q + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !det.meas_en) begin
      st_q          <= asp_pkg::DET_WAIT;
      det.valid     <= 1'b0;
      det.err       <= 1'b0;
      det.ratio     <= 10'h000;
      det.frame_cyc <= 16'h0000;
      det.rate_idx  <= 3'h0;
      det.fam44     <= 1'b0;
    end else if (tmo && (st_q != asp_pkg::DET_WAIT)) begin
      st_q      <= asp_pkg::DET_WAIT;
      det.valid <= 1'b0;
      det.err   <= 1'b1;
    end else if (det.fs_rise) begin
      unique case (st_q)
        asp_pkg::DET_WAIT: st_q <= asp_pkg::DET_MEAS;
        asp_pkg::DET_MEAS, asp_pkg::DET_LOCK: begin
          if (fit && ((st_q == asp_pkg::DET_MEAS) || (bc_q == det.ratio))) begin
            st_q          <= asp_pkg::DET_LOCK;
            det.valid     <= 1'b1;
            det.err       <= 1'b0;
            det.ratio     <= bc_q;
            det.frame_cyc <= cyc_q;
            det.rate_idx  <= rate_idx;
            det.fam44     <= fam44;
          end else begin
            st_q      <= asp_pkg::DET_MEAS;
            det.valid <= 1'b0;
            det.err   <= 1'b1;
          end
        end
        default: st_q <= asp_pkg::DET_WAIT;
      endcase
    end
  end
endmodule // asp_clk_detect

//--- hw/asp_serial_port.sv
// two-slot i2s / left-justified audio serial port with ahb-lite registers
`timescale 1ns/1ns
module asp_serial_port #(
  parameter int BCLK_HALF = asp_pkg::BCLK_HALF_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [1:0]  format_role_strap,
  input  wire logic        word_len_sel,
  input  wire logic        io_supply_level,
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe,
  input  wire logic        frame_sync_in,
  output logic             frame_sync_out,
  output logic             frame_sync_oe,
  input  wire logic        sdin,
  output logic             sdout,
  output logic             sdout_oe,
  output logic             mod_clk_en,
  output logic             filt_clk_en,
  output logic             ctrl_clk_en,
  output logic             clk_locked,
  output logic             clk_error
);
  localparam logic [15:0] CTL_FRAME = 16'(asp_pkg::CTL_RATIO * 2 * BCLK_HALF);
  localparam logic [4:0]  FS_HALF_M1 = 5'(asp_pkg::CTL_RATIO / 2 - 1);
  localparam logic [15:0] HALF_M1 = 16'(BCLK_HALF - 1);

  asp_det_if det_if ();

  asp_pkg::asp_mode_e mode_q;
  logic               strap_done_q;
  logic               ctl_q;
  logic               lj_q;
  logic [5:0]         wl_q;
  logic [31:0]        ctrl_q;
  logic               en;
  logic [31:0]        tx_left_q;
  logic [31:0]        tx_right_q;
  logic [31:0]        rx_left_q;
  logic [31:0]        rx_right_q;
  logic               ap_q;
  logic               wr_q;
  logic [7:0]         addr_q;
  logic [31:0]        hrdata_q;
  logic [31:0]        rd_mux;
  logic [15:0]        div_q;
  logic               gen_bclk_q;
  logic               gen_fs_q;
  logic [4:0]         fs_cnt_q;
  logic               gen_rise;
  logic               bclk_now;
  logic               bclk_prev_q;
  logic               bclk_rise;
  logic               bclk_fall;
  logic               fs_now;
  logic               fs_fall_q;
  logic               fs_at_rise_q;
  logic               slot_new;
  logic               slot_right_q;
  logic [8:0]         bit_cnt_q;
  logic [8:0]         cnt_d;
  logic [8:0]         dly;
  logic [8:0]         pos;
  logic               tx_on;
  logic [31:0]        tx_cur_q;
  logic [31:0]        word_sel;
  logic               msb_bit;
  logic               sdout_q;
  logic               sdout_oe_q;
  logic [8:0]         rpos;
  logic               rx_on;
  logic [31:0]        rx_sh_q;
  logic [31:0]        rx_word;
  logic [15:0]        cfg_frame_q;
  logic               cfg_ok_q;
  logic [15:0]        mod_div_q;
  logic [15:0]        mod_per;
  logic [5:0]         mod_cnt_q;
  logic               mod_en_q;
  logic               filt_en_q;
  logic               ctrl_en_q;

  // strap is caught once, after reset release, then held
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      mode_q       <= asp_pkg::ASP_TGT_I2S;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_q       <= asp_pkg::asp_mode_e'(format_role_strap);
    end
  end

  always_comb begin
    unique case (mode_q)
      asp_pkg::ASP_CTL_I2S: begin
        ctl_q = 1'b1;
        lj_q  = 1'b0;
      end
      asp_pkg::ASP_TGT_LJ: begin
        ctl_q = 1'b0;
        lj_q  = 1'b1;
      end
      default: begin
        ctl_q = 1'b0;
        lj_q  = 1'b0;
      end
    endcase
  end

  // controller role runs fixed 32-bit words
  assign wl_q = (ctl_q || !word_len_sel) ? asp_pkg::WL_LONG : asp_pkg::WL_SHORT;
  assign en   = ctrl_q[asp_pkg::CTRL_EN_POS] && strap_done_q;

  // ahb-lite slave, zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_comb begin
    unique case (haddr[7:0])
      asp_pkg::ADDR_CTRL:     rd_mux = ctrl_q;
      asp_pkg::ADDR_STATUS:   rd_mux = ({31'h0, cfg_ok_q} << asp_pkg::ST_LOCK_POS)
                                     | ({31'h0, det_if.err} << asp_pkg::ST_ERR_POS)
                                     | ({31'h0, det_if.fam44} << asp_pkg::ST_FAM_POS)
                                     | ({29'h0, det_if.rate_idx} << asp_pkg::ST_RATE_POS)
                                     | ({22'h0, det_if.ratio} << asp_pkg::ST_RATIO_POS)
                                     | ({30'h0, mode_q} << asp_pkg::ST_MODE_POS);
      asp_pkg::ADDR_TX_LEFT:  rd_mux = tx_left_q;
      asp_pkg::ADDR_TX_RIGHT: rd_mux = tx_right_q;
      asp_pkg::ADDR_RX_LEFT:  rd_mux = rx_left_q;
      asp_pkg::ADDR_RX_RIGHT: rd_mux = rx_right_q;
      asp_pkg::ADDR_FRAME:    rd_mux = {16'h0000, cfg_frame_q};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ap_q     <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ap_q <= hsel && htrans[1] && hready;
      wr_q <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready) begin
        addr_q <= haddr[7:0];
        if (!hwrite) begin
          hrdata_q <= rd_mux;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q     <= asp_pkg::CTRL_RST;
      tx_left_q  <= 32'h0000_0000;
      tx_right_q <= 32'h0000_0000;
    end else if (ap_q && wr_q) begin
      if (addr_q == asp_pkg::ADDR_CTRL) begin
        ctrl_q <= hwdata & 32'h0000_0001;
      end
      if (addr_q == asp_pkg::ADDR_TX_LEFT) begin
        tx_left_q <= hwdata;
      end
      if (addr_q == asp_pkg::ADDR_TX_RIGHT) begin
        tx_right_q <= hwdata;
      end
    end
  end

  // controller bit clock and frame sync generator
  assign gen_rise = ctl_q && en && (div_q == HALF_M1) && !gen_bclk_q;

  always_ff @(posedge mclk) begin
    if (rst || !ctl_q || !en) begin
      div_q      <= 16'h0000;
      gen_bclk_q <= 1'b0;
    end else if (div_q == HALF_M1) begin
      div_q      <= 16'h0000;
      gen_bclk_q <= !gen_bclk_q;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !ctl_q || !en) begin
      fs_cnt_q <= 5'h00;
      gen_fs_q <= 1'b1;
    end else if (gen_rise) begin
      fs_cnt_q <= fs_cnt_q + 5'h01;
      if (fs_cnt_q == FS_HALF_M1) begin
        gen_fs_q <= !gen_fs_q;
      end
    end
  end

  assign bclk_out       = gen_bclk_q;
  assign frame_sync_out = gen_fs_q;
  assign bclk_oe        = ctl_q && strap_done_q;
  assign frame_sync_oe  = ctl_q && strap_done_q;

  // edges of whichever bit clock is live
  assign bclk_now  = ctl_q ? gen_bclk_q : bclk_in;
  assign fs_now    = ctl_q ? gen_fs_q : frame_sync_in;
  assign bclk_rise = en && bclk_now && !bclk_prev_q;
  assign bclk_fall = en && !bclk_now && bclk_prev_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bclk_prev_q  <= 1'b0;
      fs_at_rise_q <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_now;
      if (bclk_rise) begin
        fs_at_rise_q <= fs_now;
      end
    end
  end

  assign det_if.bclk_rise = bclk_rise;
  assign det_if.fs_rise   = bclk_rise && fs_now && !fs_at_rise_q;
  assign det_if.io33      = io_supply_level;
  assign det_if.meas_en   = en && !ctl_q;

  asp_clk_detect u_det (
    .mclk (mclk),
    .rst  (rst),
    .det  (det_if)
  );

  // slot tracking: a sync change opens a new slot
  assign slot_new = fs_now != fs_fall_q;
  assign cnt_d    = slot_new ? 9'h000 : ((bit_cnt_q == 9'h1FF) ? bit_cnt_q : bit_cnt_q + 9'h001);
  assign dly      = lj_q ? 9'h000 : 9'h001;
  assign pos      = cnt_d - dly;
  assign tx_on    = (cnt_d >= dly) && (pos < {3'h0, wl_q});
  assign word_sel = slot_new ? ((fs_now ^ lj_q) ? tx_right_q : tx_left_q) : tx_cur_q;
  assign msb_bit  = word_sel[5'(wl_q - 6'h01)];

  always_ff @(posedge mclk) begin
    if (rst) begin
      fs_fall_q    <= 1'b0;
      bit_cnt_q    <= 9'h1FF;
      slot_right_q <= 1'b0;
      tx_cur_q     <= 32'h0000_0000;
    end else if (bclk_fall) begin
      fs_fall_q <= fs_now;
      bit_cnt_q <= cnt_d;
      if (slot_new) begin
        slot_right_q <= fs_now ^ lj_q;
        tx_cur_q     <= word_sel;
      end
    end
  end

  // launch on falling edges, msb first
  always_ff @(posedge mclk) begin
    if (rst || !en) begin
      sdout_q    <= 1'b0;
      sdout_oe_q <= 1'b0;
    end else if (bclk_fall) begin
      sdout_oe_q <= tx_on;
      sdout_q    <= tx_on && word_sel[5'(6'(wl_q - 6'h01) - pos[5:0])];
    end
  end

  assign sdout    = sdout_q;
  assign sdout_oe = sdout_oe_q;

  // capture on rising edges, sign-extend short words
  assign rpos    = bit_cnt_q - dly;
  assign rx_on   = (bit_cnt_q >= dly) && (rpos < {3'h0, wl_q});
  assign rx_word = (wl_q == asp_pkg::WL_SHORT)
                 ? {{8{rx_sh_q[22]}}, rx_sh_q[22:0], sdin}
                 : {rx_sh_q[30:0], sdin};

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_sh_q    <= 32'h0000_0000;
      rx_left_q  <= 32'h0000_0000;
      rx_right_q <= 32'h0000_0000;
    end else if (bclk_rise && rx_on) begin
      rx_sh_q <= {rx_sh_q[30:0], sdin};
      if (rpos == 9'(wl_q - 6'h01)) begin
        if (slot_right_q) begin
          rx_right_q <= rx_word;
        end else begin
          rx_left_q <= rx_word;
        end
      end
    end
  end

  // applied clock setting: detected in target, fixed in controller
  always_ff @(posedge mclk) begin
    if (rst || !en) begin
      cfg_frame_q <= 16'h0000;
      cfg_ok_q    <= 1'b0;
    end else if (ctl_q) begin
      cfg_frame_q <= CTL_FRAME;
      cfg_ok_q    <= 1'b1;
    end else if (det_if.valid && det_if.fs_rise) begin
      cfg_frame_q <= det_if.frame_cyc;
      cfg_ok_q    <= 1'b1;
    end else if (!det_if.valid) begin
      cfg_ok_q <= 1'b0;
    end
  end

  // 64x frame-rate divider stands in for the pll output
  assign mod_per = (cfg_frame_q[15:6] == 10'h000) ? 16'h0001 : {6'h00, cfg_frame_q[15:6]};

  always_ff @(posedge mclk) begin
    // stop pulses in the same cycle the lock drops, not one later
    if (rst || !cfg_ok_q || !en || (!ctl_q && !det_if.valid)) begin
      mod_div_q <= 16'h0000;
      mod_cnt_q <= 6'h00;
      mod_en_q  <= 1'b0;
      filt_en_q <= 1'b0;
      ctrl_en_q <= 1'b0;
    end else begin
      mod_en_q  <= 1'b0;
      filt_en_q <= 1'b0;
      ctrl_en_q <= 1'b0;
      if (mod_div_q >= mod_per - 16'h0001) begin
        mod_div_q <= 16'h0000;
        mod_cnt_q <= mod_cnt_q + 6'h01;
        mod_en_q  <= 1'b1;
        filt_en_q <= mod_cnt_q == 6'h3F;
        ctrl_en_q <= mod_cnt_q[2:0] == 3'h7;
      end else begin
        mod_div_q <= mod_div_q + 16'h0001;
      end
    end
  end

  assign mod_clk_en  = mod_en_q;
  assign filt_clk_en = filt_en_q;
  assign ctrl_clk_en = ctrl_en_q;
  assign clk_locked  = cfg_ok_q;
  assign clk_error   = det_if.err;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_lj_start;
    bclk_fall && slot_new && lj_q;
  endsequence
  sequence s_i2s_start;
    bclk_fall && slot_new && !lj_q;
  endsequence

  property p_lj_msb;
    s_lj_start |=> sdout_oe_q && (sdout_q == $past(msb_bit));
  endproperty
  a_lj_msb: assert property (p_lj_msb) else $error("lj msb not at slot start");

  property p_i2s_gap;
    s_i2s_start |=> !sdout_oe_q;
  endproperty
  a_i2s_gap: assert property (p_i2s_gap) else $error("i2s delay cycle driven");

  property p_i2s_msb;
    bclk_fall && !slot_new && !lj_q && (bit_cnt_q == 9'h000)
      |=> sdout_oe_q && (sdout_q == $past(msb_bit));
  endproperty
  a_i2s_msb: assert property (p_i2s_msb) else $error("i2s msb misplaced");

  property p_tail_hiz;
    bclk_fall && !tx_on |=> !sdout_oe_q;
  endproperty
  a_tail_hiz: assert property (p_tail_hiz) else $error("data driven past word");

  property p_rx_shift;
    bclk_rise && rx_on |=> rx_sh_q[0] == $past(sdin);
  endproperty
  a_rx_shift: assert property (p_rx_shift) else $error("rx bit not taken");

  property p_ctl_fs;
    ctl_q && $changed(gen_fs_q) |-> $past(gen_rise) && gen_bclk_q;
  endproperty
  a_ctl_fs: assert property (p_ctl_fs) else $error("sync moved off rise");

  property p_pin_dir;
    strap_done_q |-> (bclk_oe == (mode_q == asp_pkg::ASP_CTL_I2S)) && (frame_sync_oe == bclk_oe);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("clock pin direction wrong");

  property p_lock_cfg;
    !ctl_q && en && det_if.valid && det_if.fs_rise
      |=> cfg_ok_q && (cfg_frame_q == $past(det_if.frame_cyc));
  endproperty
  a_lock_cfg: assert property (p_lock_cfg) else $error("setting not applied");

  property p_ratio_ok;
    det_if.valid |-> (det_if.ratio >= 10'h010) && (det_if.ratio <= 10'h200) && !det_if.err;
  endproperty
  a_ratio_ok: assert property (p_ratio_ok) else $error("bad ratio accepted");

  property p_slot_pair;
    bclk_fall && slot_new |=> slot_right_q == ($past(fs_now) ^ $past(lj_q));
  endproperty
  a_slot_pair: assert property (p_slot_pair) else $error("slot side wrong");

  property p_mod_gate;
    mod_en_q |-> cfg_ok_q;
  endproperty
  a_mod_gate: assert property (p_mod_gate) else $error("clock enable while unlocked");
endmodule // asp_serial_port

//--- verif/asp_host_model.sv
// audio host model: bit clock, sync and data for a target i2s or lj port
`timescale 1ns/1ns
module asp_host_model (
  input  wire logic        mclk,
  input  wire logic        run,
  input  wire logic        lj,
  input  wire logic [47:0] tx_frame,
  input  wire logic        sdout,
  input  wire logic        sdout_oe,
  output logic             bclk,
  output logic             sync,
  output logic             sdin,
  output logic [47:0]      rx_frame
);
  int b = 0;
  int k;
  int s;
  initial begin
    bclk = 1'b1;
    sync = 1'b1;
    sdin = 1'b0;
    rx_frame = '0;
    forever begin
      @(posedge mclk);
      if (run) begin
        // 96 bclk of 13 mclk: two 48-bit slots of 24-bit words, 1248 mclk a frame
        s = b / 48;
        k = b % 48 - (lj ? 0 : 1);
        bclk <= 1'b0;
        sync <= lj ? (s == 0) : (s == 1);
        sdin <= (k >= 0 && k < 24) ? tx_frame[47 - 24 * s - k] : 1'b1;
        repeat (6) @(posedge mclk);
        bclk <= 1'b1;
        // a floating output shows up as unknown
        if (k >= 0 && k < 24) rx_frame[47 - 24 * s - k] <= sdout_oe ? sdout : 1'bx;
        repeat (6) @(posedge mclk);
        b = (b + 1) % 96;
      end else begin
        sdin <= ~sdin;
        b = 0;
      end
    end
  end
endmodule // asp_host_model

//--- verif/tb_asp_serial_port.sv
// self-checking bench for the audio serial port
`timescale 1ns/1ns
module tb_asp_serial_port;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [1:0]  strap = 2'b00;
  logic        run = 1'b0;
  logic        lj = 1'b0;
  logic [47:0] tx_frame = {24'h9A5C33, 24'h1234A5};
  logic        hreadyout, hresp, bclk_out, bclk_oe, fs_out, fs_oe, sdout, sdout_oe;
  logic        mod_en, filt_en, ctrl_en, clk_locked, clk_error, h_bclk, h_sync, sdin;
  logic [31:0] hrdata, v;
  logic [47:0] rx_frame;
  int          error_cnt = 0;
  int          checks = 0;
  always #50 mclk = ~mclk;
  asp_serial_port i_asp_serial_port (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .format_role_strap(strap), .word_len_sel(1'b1),
    .io_supply_level(1'b1), .bclk_in(bclk_oe ? bclk_out : h_bclk), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .frame_sync_in(fs_oe ? fs_out : h_sync), .frame_sync_out(fs_out),
    .frame_sync_oe(fs_oe), .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe),
    .mod_clk_en(mod_en), .filt_clk_en(filt_en), .ctrl_clk_en(ctrl_en),
    .clk_locked(clk_locked), .clk_error(clk_error));
  asp_host_model i_asp_host_model (
    .mclk(mclk), .run(run), .lj(lj), .tx_frame(tx_frame), .sdout(sdout), .sdout_oe(sdout_oe),
    .bclk(h_bclk), .sync(h_sync), .sdin(sdin), .rx_frame(rx_frame));
  task automatic close_out();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(v, exp);
  endtask
  task automatic t_regs();
    rd(asp_pkg::ADDR_CTRL, asp_pkg::CTRL_RST);
    chk(hresp, 32'h0);
    rd(32'h0000_001C, 32'h0);
    ahb(1'b1, asp_pkg::ADDR_TX_LEFT, 32'h00C3_A5F0);
    rd(asp_pkg::ADDR_TX_LEFT, 32'h00C3_A5F0);
  endtask
  task automatic t_target();
    int m, f, c;
    ahb(1'b1, asp_pkg::ADDR_TX_RIGHT, 32'h005A_0F33);
    ahb(1'b1, asp_pkg::ADDR_CTRL, 32'h1);
    run <= 1'b1;
    repeat (3744) @(posedge mclk);
    m = 0;
    f = 0;
    c = 0;
    // two filter periods: 1x, 64x and 8x the frame rate
    repeat (2432) begin
      @(posedge mclk);
      m += mod_en;
      f += filt_en;
      c += ctrl_en;
    end
    chk(f, 2);
    chk(m >= 127 && m <= 129, 1);
    chk(c >= 15 && c <= 17, 1);
    rd(asp_pkg::ADDR_STATUS, 32'h0000_6001);
    rd(asp_pkg::ADDR_RX_LEFT, 32'hFF9A_5C33);
    rd(asp_pkg::ADDR_RX_RIGHT, 32'h0012_34A5);
    chk({8'h00, rx_frame[47:24]}, 32'h00C3_A5F0);
    chk({8'h00, rx_frame[23:0]}, 32'h005A_0F33);
  endtask
  task automatic t_timeout();
    run <= 1'b0;
    repeat (2100) @(posedge mclk);
    chk({clk_locked, clk_error}, 32'h1);
  endtask
  task automatic t_lj();
    strap <= 2'b10;
    lj <= 1'b1;
    tx_frame <= {24'h3C5A96, 24'hE10F78};
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    ahb(1'b1, asp_pkg::ADDR_TX_LEFT, 32'h0096_5A3C);
    ahb(1'b1, asp_pkg::ADDR_TX_RIGHT, 32'h0071_E2D4);
    ahb(1'b1, asp_pkg::ADDR_CTRL, 32'h1);
    run <= 1'b1;
    repeat (3744) @(posedge mclk);
    rd(asp_pkg::ADDR_STATUS, 32'h0020_6001);
    rd(asp_pkg::ADDR_RX_LEFT, 32'h003C_5A96);
    rd(asp_pkg::ADDR_RX_RIGHT, 32'hFFE1_0F78);
    chk({8'h00, rx_frame[47:24]}, 32'h0096_5A3C);
    chk({8'h00, rx_frame[23:0]}, 32'h0071_E2D4);
    run <= 1'b0;
  endtask
  task automatic t_ctl();
    int r, n;
    logic pb, pf;
    strap <= 2'b01;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    ahb(1'b1, asp_pkg::ADDR_CTRL, 32'h1);
    chk({bclk_oe, fs_oe}, 32'h3);
    pb = bclk_out;
    pf = fs_out;
    r = 0;
    n = 0;
    repeat (1000) begin
      @(posedge mclk);
      if (bclk_out && !pb) r++;
      if (fs_out !== pf) begin
        chk(bclk_out && !pb, 1);
        if (n > 0) chk(r, asp_pkg::CTL_RATIO / 2);
        n++;
        r = 0;
      end
      pb = bclk_out;
      pf = fs_out;
    end
    chk(n > 4, 1);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    // bench ran past its expected span
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_target();
    t_timeout();
    t_lj();
    t_ctl();
    close_out();
  end
endmodule // tb_asp_serial_port
